//--- rtl/suspc_params.svh
// Constants of the serial unit: offsets, field positions, reset values
`ifndef SUSPC_PARAMS_SVH
`define SUSPC_PARAMS_SVH
// Register offsets
`define SUSPC_A_GATE 8'h00
`define SUSPC_A_SE   8'h01
`define SUSPC_A_SS   8'h02
`define SUSPC_A_ST   8'h03
`define SUSPC_A_SOE  8'h04
`define SUSPC_A_SO   8'h05
`define SUSPC_A_NF   8'h06
`define SUSPC_A_SSC  8'h07
`define SUSPC_A_PS   8'h08
`define SUSPC_A_MODE 8'h10
`define SUSPC_A_DATA 8'h12
`define SUSPC_A_STAT 8'h14
// Field positions
`define SUSPC_B_GATE 2
`define SUSPC_B_CKO  8
`define SUSPC_B_DIV  8
// Reset value of the output level register
`define SUSPC_SO_RST 16'h0303
// Smallest half-period divider per channel
`define SUSPC_CH0_MIN_DIV 7'h00
`define SUSPC_CH1_MIN_DIV 7'h01
`endif

//--- rtl/suspc_pkg.sv
// Types, reset state and bit helpers of the serial unit
package suspc_pkg;
   typedef logic [7:0]  suspc_addr_t;   // Register address
   typedef logic [15:0] suspc_word_t;   // Register data
   typedef logic [1:0]  suspc_chvec_t;  // One bit per channel
   // Transfer phase of a channel
   typedef enum logic [1:0] {
      SUSPC_IDLE  = 2'b00,
      SUSPC_LEAD  = 2'b01,
      SUSPC_TRAIL = 2'b10
   } suspc_phase_t;
   // State of one channel
   typedef struct packed {
      logic master, dap, ckp, lsbFirst, len8, intSel;
      logic [6:0]   div;
      logic [7:0]   txBuf, rxBuf, shift;
      logic [2:0]   bitCnt;
      logic [6:0]   halfCnt;
      suspc_phase_t phase;
      logic bufFull, rxFull, ovf, stPend, rxHold;
      logic sckS1, sckS2, sckS3, sdiS1, sdiS2, sdiS3, sdiFilt;
      logic se, soe, cko, so, sckOe, sdoOe, irq;
   } suspc_chan_t;
   // State of the whole unit
   typedef struct packed {
      suspc_chan_t [1:0] ch;
      logic gate, nfEn, swc, ssec;
      logic [3:0]  psSel;
      logic [14:0] psCnt;
      logic [15:0] rdata;
   } suspc_state_t;
   localparam suspc_chan_t SUSPC_CHAN_RST =
      '{phase: SUSPC_IDLE, cko: 1'b1, so: 1'b1, default: '0};
   localparam suspc_state_t SUSPC_RST =
      '{ch: {SUSPC_CHAN_RST, SUSPC_CHAN_RST}, default: '0};
   // Bit that leaves the shifter next
   function automatic logic suspc_out_bit(logic [7:0] sh, logic lsb, logic l8);
      return lsb ? sh[0] : (l8 ? sh[7] : sh[6]);
   endfunction
   // Shift one received bit in
   function automatic logic [7:0] suspc_shift_in(logic [7:0] sh, logic lsb, logic l8, logic b);
      if (!lsb) return {sh[6:0], b};
      return l8 ? {b, sh[7:1]} : {1'b0, b, sh[6:1]};
   endfunction
endpackage

//--- rtl/suspc_top.sv
// Two-channel clocked serial unit with gating, stop and pin control
//
// Notes on behaviour
// - Stopped channel idles; pins return to port.
// - Gate bit cleared stops whole unit.
// - Gate off: writes ignored, reads give defaults, except gate, filter and standby.
// - Stop trigger stops channel, then self-clears.
// - Status read-only; clock level writable when stopped.
// - Output disabled: data level writes set sdoOut, sdoOe stays low.
// - Three wires, 7/8 bits, phase, bit order.
// - Master/slave, clock phase, prescaler plus divider.
// - Master fclk/2 channel 0, fclk/4 otherwise.
// - Transfer-end or buffer-empty event, overrun flag.
// - Channel 0 only receives during stop mode.
// - Clocked mode exists on channels 0, 1.
// - Filter: synchronise, then two matching samples.
// - Output enabled: data level writes ignored.
// - Level bits reset high, others low.
`timescale 1ns/10ps
`include "suspc_params.svh"
`default_nettype none
module suspc_top (
   input  wire logic                 ref_clk,   // System clock, 100 MHz
   input  wire logic                 srst,      // Synchronous reset
   input  wire suspc_pkg::suspc_addr_t  busAddr,   // Register address
   input  wire suspc_pkg::suspc_word_t  busWdata,  // Write data
   input  wire logic                 busWe,     // Write strobe
   input  wire logic                 busRe,     // Read strobe
   output var  suspc_pkg::suspc_word_t  busRdata,  // Read data
   input  wire logic                 stopMode,  // Chip in stop mode
   input  wire suspc_pkg::suspc_chvec_t sckIn,     // Clock pin level
   input  wire suspc_pkg::suspc_chvec_t sdiIn,     // Data input pin
   output var  suspc_pkg::suspc_chvec_t sckOut,    // Clock pin drive
   output var  suspc_pkg::suspc_chvec_t sckOe,     // Clock pin enable
   output var  suspc_pkg::suspc_chvec_t sdoOut,    // Data pin drive
   output var  suspc_pkg::suspc_chvec_t sdoOe,     // Data pin enable
   output var  suspc_pkg::suspc_chvec_t irq,       // Channel event pulse
   output var  suspc_pkg::suspc_chvec_t chanActive // Channel enabled
);
   import suspc_pkg::*;

   suspc_state_t stateReg;   // All state
   suspc_state_t stateNext;  // Next state
   suspc_chan_t  c;          // Channel work copy
   logic [14:0]  psMask;     // Prescaler select mask
   logic [6:0]   divEff;     // Clamped divider
   logic         mckTick;    // Operating clock tick
   logic         edgeEv;     // Serial clock edge
   logic         rxBit;      // Sampled input bit
   logic         wakeArm;    // Stop-mode reception armed
   logic         ovfSet;     // Overrun set now
   logic         rxSet;      // Receive buffer filled now
   logic         wrOk;       // Unit write permitted

   // Outputs come straight from state flops
   assign busRdata = stateReg.rdata;
   always_comb begin
      for (int k = 0; k < 2; k++) begin
         sckOut[k]     = stateReg.ch[k].cko;
         sckOe[k]      = stateReg.ch[k].sckOe;
         sdoOut[k]     = stateReg.ch[k].so;
         sdoOe[k]      = stateReg.ch[k].sdoOe;
         irq[k]        = stateReg.ch[k].irq;
         chanActive[k] = stateReg.ch[k].se;
      end
   end

   // Next-state logic of the whole unit
   always_comb begin
      stateNext = stateReg;
      c         = stateReg.ch[0];
      divEff    = 7'h00;
      edgeEv    = 1'b0;
      rxBit     = 1'b0;
      wakeArm   = 1'b0;
      ovfSet    = 1'b0;
      rxSet     = 1'b0;
      wrOk      = busWe && stateReg.gate;
      // Prescaler runs only with the unit clock on
      psMask = (15'h0001 << stateReg.psSel) - 15'h0001;
      mckTick = (stateReg.psCnt & psMask) == psMask;
      stateNext.psCnt = stateReg.gate ? stateReg.psCnt + 15'h0001 : 15'h0000;
      // Unit-level writes; filter and standby stay writable
      if (busWe) begin
         case (busAddr)
            `SUSPC_A_GATE: stateNext.gate = busWdata[`SUSPC_B_GATE];
            `SUSPC_A_NF: stateNext.nfEn = busWdata[0];
            `SUSPC_A_SSC: begin
               stateNext.swc  = busWdata[0];
               stateNext.ssec = busWdata[1];
            end
            `SUSPC_A_PS: begin
               if (stateReg.gate) begin
                  stateNext.psSel = busWdata[3:0];
               end
            end
            default: ;
         endcase
      end
      // Gated unit holds its control at defaults
      if (!stateReg.gate) begin
         stateNext.psSel = 4'h0;
      end
      // Unit-level reads
      stateNext.rdata = 16'h0000;
      if (busRe) begin
         case (busAddr)
            `SUSPC_A_GATE: stateNext.rdata[`SUSPC_B_GATE] = stateReg.gate;
            `SUSPC_A_SE: stateNext.rdata[1:0] = {stateReg.ch[1].se, stateReg.ch[0].se};
            `SUSPC_A_ST: stateNext.rdata[1:0] = {stateReg.ch[1].stPend, stateReg.ch[0].stPend};
            `SUSPC_A_SOE: stateNext.rdata[1:0] = {stateReg.ch[1].soe, stateReg.ch[0].soe};
            `SUSPC_A_SO: begin
               stateNext.rdata[9:8] = {stateReg.ch[1].cko, stateReg.ch[0].cko};
               stateNext.rdata[1:0] = {stateReg.ch[1].so, stateReg.ch[0].so};
            end
            `SUSPC_A_NF: stateNext.rdata[0] = stateReg.nfEn;
            `SUSPC_A_SSC: stateNext.rdata[1:0] = {stateReg.ssec, stateReg.swc};
            `SUSPC_A_PS: stateNext.rdata[3:0] = stateReg.psSel;
            default: ;
         endcase
      end
      // Per-channel engine and registers
      for (int i = 0; i < 2; i++) begin
         c = stateReg.ch[i];
         c.irq = 1'b0;
         // Event flags belong to this channel only
         ovfSet = 1'b0;
         rxSet = 1'b0;
         if (!stateReg.gate) begin
            c = SUSPC_CHAN_RST;
         end
         // Trigger drops once the channel reads stopped
         if (c.stPend && !c.se) begin
            c.stPend = 1'b0;
         end
         // Channel 1 cannot run its clock faster than fclk/4
         divEff = c.div;
         if (i == 1 && c.div < `SUSPC_CH1_MIN_DIV) begin
            divEff = `SUSPC_CH1_MIN_DIV;
         end
         edgeEv = c.master ? (mckTick && c.halfCnt == 7'h00) : (c.sckS2 != c.sckS3);
         rxBit = (i == 0 && stateReg.nfEn) ? c.sdiFilt : c.sdiS2;
         wakeArm = (i == 0) && stateReg.swc && stopMode && !c.master;
         // Half-period counter of the master clock
         if (c.phase != SUSPC_IDLE && c.master && mckTick) begin
            c.halfCnt = (c.halfCnt == 7'h00) ? divEff : c.halfCnt - 7'h01;
         end
         case (c.phase)
            SUSPC_IDLE: begin
               // Start a word when data waits or wake reception is armed
               if (c.se && (c.bufFull || wakeArm)) begin
                  c.shift = c.bufFull ? c.txBuf : 8'hFF;
                  c.bufFull = 1'b0;
                  c.bitCnt = 3'h0;
                  c.halfCnt = divEff;
                  c.phase = SUSPC_LEAD;
                  c.cko = ~c.ckp;
                  if (c.dap && c.soe) begin
                     c.so = suspc_out_bit(c.shift, c.lsbFirst, c.len8);
                  end
                  c.irq = c.intSel;
               end
            end
            SUSPC_LEAD: begin
               // Leading edge: capture early or present the bit
               if (edgeEv) begin
                  if (c.master) begin
                     c.cko = ~c.cko;
                  end
                  c.rxHold = rxBit;
                  if (!c.dap && c.soe) begin
                     c.so = suspc_out_bit(c.shift, c.lsbFirst, c.len8);
                  end
                  c.phase = SUSPC_TRAIL;
               end
            end
            SUSPC_TRAIL: begin
               // Trailing edge: shift, and finish after the last bit
               if (edgeEv) begin
                  if (c.master) begin
                     c.cko = ~c.cko;
                  end
                  c.shift = suspc_shift_in(c.shift, c.lsbFirst, c.len8,
                                           c.dap ? c.rxHold : rxBit);
                  if (c.bitCnt == (c.len8 ? 3'h7 : 3'h6)) begin
                     c.phase = SUSPC_IDLE;
                     rxSet = 1'b1;
                     ovfSet = c.rxFull;
                     c.rxBuf = c.len8 ? c.shift : {1'b0, c.shift[6:0]};
                     c.rxFull = 1'b1;
                     c.irq = ~c.intSel;
                  end else begin
                     c.bitCnt = c.bitCnt + 3'h1;
                     c.phase = SUSPC_LEAD;
                     if (c.dap && c.soe) begin
                        c.so = suspc_out_bit(c.shift, c.lsbFirst, c.len8);
                     end
                  end
               end
            end
            default: c.phase = SUSPC_IDLE;
         endcase
         if (ovfSet) begin
            c.ovf = 1'b1;
         end
         // Register writes; hardware sets take priority over clears
         if (wrOk) begin
            if (busAddr == `SUSPC_A_SS && busWdata[i]) begin
               c.se = 1'b1;
            end
            if (busAddr == `SUSPC_A_ST && busWdata[i]) begin
               c.se = 1'b0;
               c.stPend = 1'b1;
               c.phase = SUSPC_IDLE;
            end
            if (busAddr == `SUSPC_A_SOE) begin
               c.soe = busWdata[i];
            end
            if (busAddr == `SUSPC_A_SO) begin
               if (!stateReg.ch[i].se) begin
                  c.cko = busWdata[`SUSPC_B_CKO + i];
               end
               if (!stateReg.ch[i].soe) begin
                  c.so = busWdata[i];
               end
            end
            if (busAddr == `SUSPC_A_MODE + 8'(i)) begin
               c.master   = busWdata[0];
               c.dap      = busWdata[1];
               c.ckp      = busWdata[2];
               c.lsbFirst = busWdata[3];
               c.len8     = busWdata[4];
               c.intSel   = busWdata[5];
               c.div      = busWdata[`SUSPC_B_DIV +: 7];
            end
            if (busAddr == `SUSPC_A_DATA + 8'(i)) begin
               c.txBuf = busWdata[7:0];
               c.bufFull = 1'b1;
            end
            if (busAddr == `SUSPC_A_STAT + 8'(i) && busWdata[0] && !ovfSet) begin
               c.ovf = 1'b0;
            end
         end
         // Channel reads; reading received data frees the buffer
         if (busRe) begin
            if (busAddr == `SUSPC_A_MODE + 8'(i)) begin
               stateNext.rdata = {1'b0, stateReg.ch[i].div, 2'b00, stateReg.ch[i].intSel,
                                  stateReg.ch[i].len8, stateReg.ch[i].lsbFirst,
                                  stateReg.ch[i].ckp, stateReg.ch[i].dap, stateReg.ch[i].master};
            end
            if (busAddr == `SUSPC_A_DATA + 8'(i)) begin
               stateNext.rdata = {8'h00, stateReg.ch[i].rxBuf};
               if (stateReg.gate && !rxSet) begin
                  c.rxFull = 1'b0;
               end
            end
            if (busAddr == `SUSPC_A_STAT + 8'(i)) begin
               stateNext.rdata[2:0] = {stateReg.ch[i].bufFull,
                                       stateReg.ch[i].phase != SUSPC_IDLE, stateReg.ch[i].ovf};
            end
         end
         // Pins go to the port while the channel is stopped
         c.sckOe = c.se && c.master;
         c.sdoOe = c.se && c.soe;
         // Synchronisers and two-sample input filter
         c.sckS1 = sckIn[i];
         c.sckS2 = stateReg.ch[i].sckS1;
         c.sckS3 = stateReg.ch[i].sckS2;
         c.sdiS1 = sdiIn[i];
         c.sdiS2 = stateReg.ch[i].sdiS1;
         c.sdiS3 = stateReg.ch[i].sdiS2;
         c.sdiFilt = stateReg.ch[i].sdiFilt;
         if (stateReg.ch[i].sdiS2 == stateReg.ch[i].sdiS3) begin
            c.sdiFilt = stateReg.ch[i].sdiS2;
         end
         stateNext.ch[i] = c;
      end
   end

   // State register
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         stateReg <= SUSPC_RST;
      end else begin
         stateReg <= stateNext;
      end
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);

   // Stop trigger write on channel 0
   sequence stopWrite0;
      busWe && stateReg.gate && busAddr == `SUSPC_A_ST && busWdata[0];
   endsequence
   // Trigger seen high, then gone one cycle later
   sequence stopDone0;
      stateReg.ch[0].stPend && !stateReg.ch[0].se ##1 !stateReg.ch[0].stPend;
   endsequence

   a_stop_clears_en: assert property (stopWrite0 |=> !chanActive[0] ##0 stopDone0)
      else $error("stop trigger did not stop channel 0");

   a_gate_off_defaults: assert property (!stateReg.gate && !(busWe && busAddr == `SUSPC_A_GATE)
      |=> !stateReg.ch[1].soe && stateReg.ch[1].cko && !chanActive[1] && stateReg.psCnt == 15'h0000)
      else $error("gated unit left control off defaults");

   a_status_readonly: assert property (busWe && busAddr == `SUSPC_A_SE && !busRe
      |=> $stable(chanActive))
      else $error("status register changed by a write");

   a_cko_write_stop: assert property (!stateReg.ch[0].se && stateReg.gate && busWe
      && busAddr == `SUSPC_A_SO |=> sckOut[0] == $past(busWdata[8]))
      else $error("clock level write on stopped channel lost");

   a_so_write_free: assert property (!stateReg.ch[1].soe && stateReg.gate && busWe
      && busAddr == `SUSPC_A_SO |=> sdoOut[1] == $past(busWdata[1]))
      else $error("data level write with output off lost");

   a_so_write_locked: assert property (stateReg.ch[0].soe && !stateReg.ch[0].se && stateReg.gate
      && busWe && busAddr == `SUSPC_A_SO |=> $stable(sdoOut[0]))
      else $error("data level changed by write with output on");

   a_reset_levels: assert property (@(posedge ref_clk) disable iff (1'b0)
      srst |=> sckOut == 2'b11 && sdoOut == 2'b11 && sckOe == 2'b00 && busRdata == 16'h0000)
      else $error("output levels wrong after reset");

   a_hold_stopped: assert property (!stateReg.ch[1].se && stateReg.gate && !busWe
      |=> $stable(sckOut[1]) && $stable(sdoOut[1]) && !sckOe[1])
      else $error("stopped channel moved its pins");

   a_ch1_rate: assert property (stateReg.ch[1].master && stateReg.ch[1].phase != SUSPC_IDLE
      && $changed(sckOut[1]) && !busWe |=> $stable(sckOut[1]))
      else $error("channel 1 clock faster than a quarter");

   a_filter_hold: assert property (stateReg.nfEn && stateReg.ch[0].sdiS2 != stateReg.ch[0].sdiS3
      |=> $stable(stateReg.ch[0].sdiFilt))
      else $error("filter passed an unconfirmed sample");

   a_end_event: assert property (stateReg.ch[0].phase == SUSPC_TRAIL && stateNext.ch[0].phase == SUSPC_IDLE
      && !stateReg.ch[0].intSel && !busWe |=> irq[0] && stateReg.ch[0].rxFull)
      else $error("transfer end without event");
endmodule
`default_nettype wire

//--- sim/suspc_partner.sv
// Far-side serial device: echoes the data line back and lets released lines float to the pull-up
`timescale 1ns/10ps
`default_nettype none
module suspc_partner (
   input  wire suspc_pkg::suspc_chvec_t sckOut,  // Clock driven by the unit
   input  wire suspc_pkg::suspc_chvec_t sckOe,   // Clock drive enable
   input  wire suspc_pkg::suspc_chvec_t sdoOut,  // Data driven by the unit
   input  wire suspc_pkg::suspc_chvec_t sdoOe,   // Data drive enable
   output var  suspc_pkg::suspc_chvec_t sckIn,   // Clock line level
   output var  suspc_pkg::suspc_chvec_t sdiIn    // Data line level
);
   import suspc_pkg::*;
   // Wire levels: the unit's drive wins, a released line is pulled high
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         sckIn[i] = sckOe[i] ? sckOut[i] : 1'b1;
         sdiIn[i] = sdoOe[i] ? sdoOut[i] : 1'b1;
      end
   end
endmodule
`default_nettype wire

//--- sim/tb_serial_unit_stop_and_pin_control.sv
// Testbench of the serial unit: register access, gating, channel stop and loopback transfers
`timescale 1ns/10ps
`include "suspc_params.svh"
`default_nettype none
module tb_serial_unit_stop_and_pin_control;
   import suspc_pkg::*;
   logic         ref_clk;              // System clock
   logic         srst;                 // Synchronous reset
   suspc_addr_t  busAddr;              // Register address
   suspc_word_t  busWdata;             // Write data
   logic         busWe;                // Write strobe
   logic         busRe;                // Read strobe
   logic         stopMode;             // Chip stop mode
   suspc_word_t  busRdata;             // Read data
   suspc_chvec_t sckIn, sdiIn;         // Line levels seen by the unit
   suspc_chvec_t sckOut, sckOe;        // Clock pin drive
   suspc_chvec_t sdoOut, sdoOe;        // Data pin drive
   suspc_chvec_t irq, chanActive;      // Events and channel status
   int           fail_count = 0;       // Mismatches
   int           n_checks = 0;         // Comparisons
   int           cyc, c0, c1;          // Cycles waited for an event

   suspc_top u_dut (.ref_clk(ref_clk), .srst(srst), .busAddr(busAddr), .busWdata(busWdata), .busWe(busWe),
      .busRe(busRe), .busRdata(busRdata), .stopMode(stopMode), .sckIn(sckIn), .sdiIn(sdiIn), .sckOut(sckOut),
      .sckOe(sckOe), .sdoOut(sdoOut), .sdoOe(sdoOe), .irq(irq), .chanActive(chanActive));
   suspc_partner u_far (.sckOut(sckOut), .sckOe(sckOe), .sdoOut(sdoOut), .sdoOe(sdoOe), .sckIn(sckIn),
      .sdiIn(sdiIn));

   // Free-running 100 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // Verdict and end of run
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Compare one value
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One-cycle write strobe
   task automatic wr(input suspc_addr_t a, input suspc_word_t d);
      @(posedge ref_clk);
      busWe    <= 1'b1;
      busAddr  <= a;
      busWdata <= d;
      @(posedge ref_clk);
      busWe    <= 1'b0;
   endtask
   // One-cycle read strobe, masked compare of the data in the following cycle
   task automatic rdx(input suspc_addr_t a, input suspc_word_t m, input suspc_word_t exp);
      @(posedge ref_clk);
      busRe   <= 1'b1;
      busAddr <= a;
      @(posedge ref_clk);
      busRe   <= 1'b0;
      #1 chk(busRdata & m, exp);
   endtask
   // Bounded wait for an event pulse of one channel
   task automatic wait_irq(input int ch);
      cyc = 0;
      while (irq[ch] !== 1'b1 && cyc < 2000) begin
         @(posedge ref_clk);
         #1 cyc++;
      end
      if (cyc >= 2000) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, irq, 2'h3);
         summarize();
      end
   endtask
   // Set up a master channel with pins high and send one word
   task automatic xfer(input int ch, input suspc_word_t mode, input logic [7:0] tx);
      wr(suspc_addr_t'(`SUSPC_A_MODE + ch), mode);
      wr(`SUSPC_A_SOE, 16'h0000);
      wr(`SUSPC_A_SO, `SUSPC_SO_RST);
      wr(`SUSPC_A_SOE, suspc_word_t'(1 << ch));
      wr(`SUSPC_A_SS, suspc_word_t'(1 << ch));
      #1 chk({15'h0, sckOe[ch] & chanActive[ch]}, 16'h0001);
      wr(`SUSPC_A_SO, 16'h0000);
      rdx(`SUSPC_A_SO, suspc_word_t'(1 << ch), suspc_word_t'(1 << ch));
      wr(suspc_addr_t'(`SUSPC_A_DATA + ch), {8'h00, tx});
      wait_irq(ch);
   endtask

   // Main sequence
   initial begin
      srst = 1'b1;
      busAddr = '0;
      busWdata = '0;
      busWe = 1'b0;
      busRe = 1'b0;
      stopMode = 1'b0;
      repeat (16) @(posedge ref_clk);
      srst <= 1'b0;
      #1 chk({12'h0, sckOut, sdoOut}, 16'h000F);
      chk({14'h0, chanActive}, 16'h0000);
      rdx(`SUSPC_A_SO, 16'hFFFF, `SUSPC_SO_RST);
      // Unit gated: control writes dropped, filter and standby registers stay live
      wr(`SUSPC_A_SOE, 16'h0003);
      rdx(`SUSPC_A_SOE, 16'hFFFF, 16'h0000);
      wr(`SUSPC_A_NF, 16'h0001);
      rdx(`SUSPC_A_NF, 16'hFFFF, 16'h0001);
      wr(`SUSPC_A_SSC, 16'h0001);
      rdx(`SUSPC_A_SSC, 16'hFFFF, 16'h0001);
      wr(`SUSPC_A_SSC, 16'h0000);
      wr(`SUSPC_A_NF, 16'h0000);
      wr(`SUSPC_A_GATE, 16'h0004);
      rdx(`SUSPC_A_GATE, 16'h0004, 16'h0004);
      rdx(8'h3F, 16'hFFFF, 16'h0000);
      // Status is read-only; levels of stopped channels are software-owned
      wr(`SUSPC_A_SE, 16'h0003);
      rdx(`SUSPC_A_SE, 16'hFFFF, 16'h0000);
      wr(`SUSPC_A_SO, 16'h0000);
      rdx(`SUSPC_A_SO, 16'hFFFF, 16'h0000);
      chk({12'h0, sckOut, sdoOut}, 16'h0000);
      // Fastest rates: channel 0 at half the clock, channel 1 clamped slower
      xfer(0, 16'h0011, 8'hA5);
      c0 = cyc;
      xfer(1, 16'h0009, 8'hC3);
      c1 = cyc;
      chk({15'h0, c0 <= 24}, 16'h0001);
      chk({15'h0, c1 >= 28}, 16'h0001);
      // Unread word overwritten: overrun flag, then cleared
      xfer(0, 16'h0311, 8'h5A);
      rdx(`SUSPC_A_STAT, 16'h0001, 16'h0001);
      rdx(`SUSPC_A_DATA, 16'h00FF, 16'h005A);
      wr(`SUSPC_A_STAT, 16'h0001);
      rdx(`SUSPC_A_STAT, 16'h0001, 16'h0000);
      // Seven bits, least significant first, on channel 1
      rdx(`SUSPC_A_DATA + 8'h01, 16'hFF80, 16'h0000);
      xfer(1, 16'h0309, 8'hC3);
      rdx(`SUSPC_A_DATA + 8'h01, 16'h00FF, 16'h0043);
      // Early data phase and inverted clock
      xfer(0, 16'h0317, 8'h3C);
      rdx(`SUSPC_A_DATA, 16'h00FF, 16'h003C);
      // Input filter on channel 0: a slow clock leaves room for its latency
      wr(`SUSPC_A_NF, 16'h0001);
      xfer(0, 16'h0511, 8'h96);
      rdx(`SUSPC_A_DATA, 16'h00FF, 16'h0096);
      wr(`SUSPC_A_NF, 16'h0000);
      // Wake reception in stop mode starts on channel 0 only
      wr(`SUSPC_A_MODE, 16'h0010);
      wr(`SUSPC_A_MODE + 8'h01, 16'h0010);
      wr(`SUSPC_A_SSC, 16'h0001);
      stopMode <= 1'b1;
      rdx(`SUSPC_A_STAT, 16'h0002, 16'h0002);
      rdx(`SUSPC_A_STAT + 8'h01, 16'h0002, 16'h0000);
      wr(`SUSPC_A_SSC, 16'h0000);
      stopMode <= 1'b0;
      wr(`SUSPC_A_ST, 16'h0001);
      // Buffer-empty event comes at load, then the word is aborted by a stop
      xfer(0, 16'h0331, 8'h81);
      chk({15'h0, cyc < 8}, 16'h0001);
      repeat (4) @(posedge ref_clk);
      wr(`SUSPC_A_ST, 16'h0001);
      repeat (2) @(posedge ref_clk);
      rdx(`SUSPC_A_ST, 16'h0001, 16'h0000);
      rdx(`SUSPC_A_SE, 16'h0001, 16'h0000);
      chk({14'h0, sckOe[0], sdoOe[0]}, 16'h0000);
      wr(`SUSPC_A_SO, 16'h0000);
      #1 chk({15'h0, sdoOut[0]}, 16'h0001);
      wr(`SUSPC_A_SOE, 16'h0000);
      wr(`SUSPC_A_SO, 16'h0201);
      #1 chk({12'h0, sckOut, sdoOut}, 16'h0009);
      // Gate dropped in mid-word: channels and prescaler return to reset state
      wr(`SUSPC_A_SOE, 16'h0002);
      wr(`SUSPC_A_DATA + 8'h01, 16'h00FF);
      repeat (6) @(posedge ref_clk);
      wr(`SUSPC_A_GATE, 16'h0000);
      @(posedge ref_clk);
      #1 chk({12'h0, chanActive, sckOe}, 16'h0000);
      chk({12'h0, sckOut, sdoOut}, 16'h000F);
      rdx(`SUSPC_A_MODE + 8'h01, 16'hFFFF, 16'h0000);
      wr(`SUSPC_A_MODE, 16'h0011);
      wr(`SUSPC_A_GATE, 16'h0004);
      rdx(`SUSPC_A_MODE, 16'hFFFF, 16'h0000);
      summarize();
   end
endmodule
`default_nettype wire
